// >>> logic/bst_pkg.sv
// Shared constants, codes and carrier types of the boundary-scan test access port.
package bst_pkg;

    // Register lengths.
    localparam int IR_LEN  = 3;
    localparam int ID_LEN  = 32;
    localparam int BSR_LEN = 85;

    // Value forced into the two low instruction bits at instruction capture.
    localparam logic [1:0] IR_CAPTURE_PAT = 2'h1;
    // Value the bypass cell takes at data capture.
    localparam logic       BYPASS_CAPTURE = 1'h0;
    // Reset value of the output-bus control latch: outputs enabled.
    localparam logic       BUS_CTRL_RESET = 1'h1;

    // Identification word layout.
    localparam int         ID_REV_LSB = 29;
    localparam int         ID_DEV_LSB = 12;
    localparam int         ID_MFR_LSB = 1;
    localparam logic       ID_MARKER  = 1'h1;

    // Consecutive high test-mode samples that always reach test-logic reset.
    localparam int RESET_TMS_EDGES = 5;

    // Instruction codes.
    typedef enum logic [2:0] {
        INSTR_EXT_TEST    = 3'b000,
        INSTR_IDENT       = 3'b001,
        INSTR_SAMPLE_FLT  = 3'b010,
        INSTR_RSVD_3      = 3'b011,
        INSTR_SAMPLE_PRE  = 3'b100,
        INSTR_RSVD_5      = 3'b101,
        INSTR_RSVD_6      = 3'b110,
        INSTR_BYPASS      = 3'b111
    } bst_instr_t;

    // Controller states.
    typedef enum logic [3:0] {
        ST_EXIT2_DR  = 4'b0000,
        ST_EXIT1_DR  = 4'b0001,
        ST_SHIFT_DR  = 4'b0010,
        ST_PAUSE_DR  = 4'b0011,
        ST_SEL_IR    = 4'b0100,
        ST_UPD_DR    = 4'b0101,
        ST_CAP_DR    = 4'b0110,
        ST_SEL_DR    = 4'b0111,
        ST_EXIT2_IR  = 4'b1000,
        ST_EXIT1_IR  = 4'b1001,
        ST_SHIFT_IR  = 4'b1010,
        ST_PAUSE_IR  = 4'b1011,
        ST_IDLE      = 4'b1100,
        ST_UPD_IR    = 4'b1101,
        ST_CAP_IR    = 4'b1110,
        ST_RESET     = 4'b1111
    } bst_state_t;

    // Control handed to the memory's output logic.
    typedef struct packed {
        logic drive_bsr;   // Output pins take the preloaded boundary values.
        logic bus_enable;  // Output bus drivers enabled while driving boundary values.
        logic float_all;   // All memory outputs forced to high impedance.
    } bst_mode_t;

    localparam bst_mode_t MODE_NORMAL = '{drive_bsr: 1'h0, bus_enable: 1'h1, float_all: 1'h0};

endpackage : bst_pkg

// >>> logic/bst_tap.sv
// Boundary-scan test access port: state machine, scan registers and memory-side controls.
// Notes on behaviour
// - Test inputs sampled on rising test clock; serial output changes on falling edge.
// - Test-mode input is pulled up, so an open pin reads high.
// - Serial data enters each register at its top bit, leaves from bit zero.
// - Five high test-mode samples in a row always reach test-logic reset.
// - Controller reset leaves normal memory reads and writes undisturbed.
// - Power-up reset resets the controller so serial output starts floating.
// - Instruction register is three bits, shifted between serial pins during instruction shift.
// - Instruction register holds identification code after power-up and in test-logic reset.
// - Instruction capture loads binary 01 into the two low instruction bits.
// - A shifted instruction takes effect only on passing instruction update.
// - Bypass register is one bit and captures zero.
// - Boundary register captures pin states, then shifts during data shift.
// - Identification instruction captures a fixed 32-bit code and shifts it out.
// - External test drives preloaded boundary values and selects the boundary register.
// - Sample-with-float selects the boundary register and floats all memory outputs.
// - Sample/preload captures pin snapshot without disturbing the memory.
// - Preload data reaches latched cell outputs; capture and preload shift concurrently.
// - Bypass instruction puts only the bypass bit in the serial path.
// - Last boundary cell, latched at data update, enables or floats bus in external test.
// - Bus control cell preset high at power-up and in test-logic reset.
// - Codes: external 000, ident 001, float sample 010, sample 100, bypass 111.
// - Ident word: revision 31:29, device 28:12, maker 11:1, bit 0 one.
`timescale 1ns/10ps
module bst_tap #(
    parameter int                 BSR_LEN     = bst_pkg::BSR_LEN,
    parameter int                 BUS_CELL    = bst_pkg::BSR_LEN - 1,
    parameter logic [2:0]         ID_REVISION = 3'h0,      // Arbitrary value.
    parameter logic [16:0]        ID_DEVICE   = 17'h0a5c3, // Arbitrary value.
    parameter logic [10:0]        ID_MAKER    = 11'h2a5    // Arbitrary value.
) (
    // Memory clock and power-up reset.
    input  wire logic               i_clk,
    input  wire logic               i_resetn,
    // Test port pins.
    input  wire logic               i_tck,
    input  wire logic               i_tms,
    input  wire logic               i_tdi,
    output logic                    o_tdo,
    output logic                    o_tdo_oe,
    // Memory pin states for capture, memory clock domain.
    input  wire logic [BSR_LEN-1:0] i_pin_state,
    // Controls to the memory output logic, memory clock domain.
    output bst_pkg::bst_mode_t      o_mode,
    output logic [BSR_LEN-1:0]      o_bsr_drive
);

    localparam logic [31:0] ID_WORD = {ID_REVISION, ID_DEVICE, ID_MAKER, bst_pkg::ID_MARKER};

    bst_pkg::bst_state_t      state_reg;
    bst_pkg::bst_state_t      state_next;
    logic [2:0]               ir_reg;
    logic [2:0]               ir_shift_reg;
    logic                     bypass_reg;
    logic [31:0]              id_reg;
    logic [BSR_LEN-1:0]       bsr_reg;
    logic [BSR_LEN-1:0]       bsr_upd_reg;
    logic [BSR_LEN-1:0]       pin_meta_reg;
    logic [BSR_LEN-1:0]       pin_sync_reg;
    bst_pkg::bst_mode_t       mode_reg;
    logic                     upd_tgl_reg;
    bst_pkg::bst_mode_t       mode_meta_reg;
    logic                     tgl_meta_reg;
    logic                     tgl_sync_reg;
    logic                     tgl_seen_reg;
    logic                     serial_out;
    logic [2:0]               instr_now;
    logic                     bus_cell_now;
    bst_pkg::bst_mode_t       mode_sync_reg;
    bst_pkg::bst_mode_t       mode_hold_reg;

    // Selects the data register path for an instruction; reserved codes fall back to bypass.
    function automatic logic [1:0] dr_select(input logic [2:0] ir);
        case (ir)
            bst_pkg::INSTR_EXT_TEST,
            bst_pkg::INSTR_SAMPLE_FLT,
            bst_pkg::INSTR_SAMPLE_PRE: dr_select = 2'h2;
            bst_pkg::INSTR_IDENT:      dr_select = 2'h1;
            default:                   dr_select = 2'h0;
        endcase
    endfunction : dr_select

    // Next controller state from the sampled test-mode level; an open pin idles high into reset.
    always_comb begin
        case (state_reg)
            bst_pkg::ST_RESET:    state_next = i_tms ? bst_pkg::ST_RESET   : bst_pkg::ST_IDLE;
            bst_pkg::ST_IDLE:     state_next = i_tms ? bst_pkg::ST_SEL_DR  : bst_pkg::ST_IDLE;
            bst_pkg::ST_SEL_DR:   state_next = i_tms ? bst_pkg::ST_SEL_IR  : bst_pkg::ST_CAP_DR;
            bst_pkg::ST_CAP_DR:   state_next = i_tms ? bst_pkg::ST_EXIT1_DR : bst_pkg::ST_SHIFT_DR;
            bst_pkg::ST_SHIFT_DR: state_next = i_tms ? bst_pkg::ST_EXIT1_DR : bst_pkg::ST_SHIFT_DR;
            bst_pkg::ST_EXIT1_DR: state_next = i_tms ? bst_pkg::ST_UPD_DR  : bst_pkg::ST_PAUSE_DR;
            bst_pkg::ST_PAUSE_DR: state_next = i_tms ? bst_pkg::ST_EXIT2_DR : bst_pkg::ST_PAUSE_DR;
            bst_pkg::ST_EXIT2_DR: state_next = i_tms ? bst_pkg::ST_UPD_DR  : bst_pkg::ST_SHIFT_DR;
            bst_pkg::ST_UPD_DR:   state_next = i_tms ? bst_pkg::ST_SEL_DR  : bst_pkg::ST_IDLE;
            bst_pkg::ST_SEL_IR:   state_next = i_tms ? bst_pkg::ST_RESET   : bst_pkg::ST_CAP_IR;
            bst_pkg::ST_CAP_IR:   state_next = i_tms ? bst_pkg::ST_EXIT1_IR : bst_pkg::ST_SHIFT_IR;
            bst_pkg::ST_SHIFT_IR: state_next = i_tms ? bst_pkg::ST_EXIT1_IR : bst_pkg::ST_SHIFT_IR;
            bst_pkg::ST_EXIT1_IR: state_next = i_tms ? bst_pkg::ST_UPD_IR  : bst_pkg::ST_PAUSE_IR;
            bst_pkg::ST_PAUSE_IR: state_next = i_tms ? bst_pkg::ST_EXIT2_IR : bst_pkg::ST_PAUSE_IR;
            bst_pkg::ST_EXIT2_IR: state_next = i_tms ? bst_pkg::ST_UPD_IR  : bst_pkg::ST_SHIFT_IR;
            bst_pkg::ST_UPD_IR:   state_next = i_tms ? bst_pkg::ST_SEL_DR  : bst_pkg::ST_IDLE;
            default:              state_next = bst_pkg::ST_RESET;
        endcase
    end

    // Controller state; power-up reset puts it in test-logic reset.
    always_ff @(posedge i_tck or negedge i_resetn) begin
        if (!i_resetn) begin
            state_reg <= bst_pkg::ST_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // Instruction shift stage: capture pattern, then shift in at the top bit.
    always_ff @(posedge i_tck or negedge i_resetn) begin
        if (!i_resetn) begin
            ir_shift_reg <= 3'h0;
        end else if (state_reg == bst_pkg::ST_CAP_IR) begin
            ir_shift_reg <= {ir_shift_reg[2], bst_pkg::IR_CAPTURE_PAT};
        end else if (state_reg == bst_pkg::ST_SHIFT_IR) begin
            ir_shift_reg <= {i_tdi, ir_shift_reg[2:1]};
        end
    end

    // Current instruction: identification after reset, new code only at instruction update.
    always_ff @(posedge i_tck or negedge i_resetn) begin
        if (!i_resetn) begin
            ir_reg <= bst_pkg::INSTR_IDENT;
        end else if (state_reg == bst_pkg::ST_RESET) begin
            ir_reg <= bst_pkg::INSTR_IDENT;
        end else if (state_reg == bst_pkg::ST_UPD_IR) begin
            ir_reg <= ir_shift_reg;
        end
    end

    // Bypass cell: captures zero, shifts the input straight through.
    always_ff @(posedge i_tck or negedge i_resetn) begin
        if (!i_resetn) begin
            bypass_reg <= 1'h0;
        end else if (state_reg == bst_pkg::ST_CAP_DR && dr_select(ir_reg) == 2'h0) begin
            bypass_reg <= bst_pkg::BYPASS_CAPTURE;
        end else if (state_reg == bst_pkg::ST_SHIFT_DR && dr_select(ir_reg) == 2'h0) begin
            bypass_reg <= i_tdi;
        end
    end

    // Identification register: captures the fixed word, shifts out from bit zero.
    always_ff @(posedge i_tck or negedge i_resetn) begin
        if (!i_resetn) begin
            id_reg <= 32'h0;
        end else if (state_reg == bst_pkg::ST_CAP_DR && dr_select(ir_reg) == 2'h1) begin
            id_reg <= ID_WORD;
        end else if (state_reg == bst_pkg::ST_SHIFT_DR && dr_select(ir_reg) == 2'h1) begin
            id_reg <= {i_tdi, id_reg[31:1]};
        end
    end

    // Pin states cross from the memory clock through two flops; mid-edge values are not exact.
    always_ff @(posedge i_tck or negedge i_resetn) begin
        if (!i_resetn) begin
            pin_meta_reg <= '0;
            pin_sync_reg <= '0;
        end else begin
            pin_meta_reg <= i_pin_state;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // Boundary shift stage: snapshot of pins, bus control cell reports its latch.
    always_ff @(posedge i_tck or negedge i_resetn) begin
        if (!i_resetn) begin
            bsr_reg <= '0;
        end else if (state_reg == bst_pkg::ST_CAP_DR && dr_select(ir_reg) == 2'h2) begin
            bsr_reg           <= pin_sync_reg;
            bsr_reg[BUS_CELL] <= bsr_upd_reg[BUS_CELL];
        end else if (state_reg == bst_pkg::ST_SHIFT_DR && dr_select(ir_reg) == 2'h2) begin
            bsr_reg <= {i_tdi, bsr_reg[BSR_LEN-1:1]};
        end
    end

    // Latched parallel cell outputs, loaded at data update; bus control presets high in reset.
    always_ff @(posedge i_tck or negedge i_resetn) begin
        if (!i_resetn) begin
            bsr_upd_reg           <= '0;
            bsr_upd_reg[BUS_CELL] <= bst_pkg::BUS_CTRL_RESET;
        end else if (state_reg == bst_pkg::ST_RESET) begin
            bsr_upd_reg[BUS_CELL] <= bst_pkg::BUS_CTRL_RESET;
        end else if (state_reg == bst_pkg::ST_UPD_DR && dr_select(ir_reg) == 2'h2) begin
            bsr_upd_reg <= bsr_reg;
        end
    end

    // Toggle marks a fresh set of latched cell values for the memory clock side.
    always_ff @(posedge i_tck or negedge i_resetn) begin
        if (!i_resetn) begin
            upd_tgl_reg <= 1'h0;
        end else if (state_reg == bst_pkg::ST_UPD_DR && dr_select(ir_reg) == 2'h2) begin
            upd_tgl_reg <= ~upd_tgl_reg;
        end
    end

    // Instruction and bus control as they stand after this edge. The mode then settles on
    // the update edge itself, even when the test clock stops in idle right after it.
    assign instr_now    = (state_reg == bst_pkg::ST_UPD_IR) ? ir_shift_reg : ir_reg;
    assign bus_cell_now = (state_reg == bst_pkg::ST_UPD_DR && dr_select(ir_reg) == 2'h2) ?
                          bsr_reg[BUS_CELL] : bsr_upd_reg[BUS_CELL];

    // Memory-side mode from the current instruction; reset returns to normal operation.
    always_ff @(posedge i_tck or negedge i_resetn) begin
        if (!i_resetn) begin
            mode_reg <= bst_pkg::MODE_NORMAL;
        end else if (state_reg == bst_pkg::ST_RESET) begin
            mode_reg <= bst_pkg::MODE_NORMAL;
        end else begin
            case (instr_now)
                bst_pkg::INSTR_EXT_TEST: begin
                    mode_reg.drive_bsr  <= 1'h1;
                    mode_reg.bus_enable <= bus_cell_now;
                    mode_reg.float_all  <= ~bus_cell_now;
                end
                bst_pkg::INSTR_SAMPLE_FLT: begin
                    mode_reg.drive_bsr  <= 1'h0;
                    mode_reg.bus_enable <= 1'h0;
                    mode_reg.float_all  <= 1'h1;
                end
                default: begin
                    mode_reg <= bst_pkg::MODE_NORMAL;
                end
            endcase
        end
    end

    // Serial output source: low bit of whichever register is in the path.
    always_comb begin
        if (state_reg == bst_pkg::ST_SHIFT_IR) begin
            serial_out = ir_shift_reg[0];
        end else begin
            case (dr_select(ir_reg))
                2'h1:    serial_out = id_reg[0];
                2'h2:    serial_out = bsr_reg[0];
                default: serial_out = bypass_reg;
            endcase
        end
    end

    // Serial output changes on the falling edge; driven only while shifting.
    always_ff @(negedge i_tck or negedge i_resetn) begin
        if (!i_resetn) begin
            o_tdo    <= 1'h0;
            o_tdo_oe <= 1'h0;
        end else begin
            o_tdo    <= serial_out;
            o_tdo_oe <= (state_reg == bst_pkg::ST_SHIFT_IR) ||
                        (state_reg == bst_pkg::ST_SHIFT_DR);
        end
    end

    // Mode levels cross to the memory clock through two flops. A new level is passed on only
    // once two samples agree, so bits that resolve on different edges never show a mixed mode.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            mode_meta_reg <= bst_pkg::MODE_NORMAL;
            mode_sync_reg <= bst_pkg::MODE_NORMAL;
            mode_hold_reg <= bst_pkg::MODE_NORMAL;
            o_mode        <= bst_pkg::MODE_NORMAL;
        end else begin
            mode_meta_reg <= mode_reg;
            mode_sync_reg <= mode_meta_reg;
            mode_hold_reg <= mode_sync_reg;
            if (mode_sync_reg == mode_hold_reg) begin
                o_mode <= mode_sync_reg;
            end
        end
    end

    // Update toggle crosses by two flops; the word is held stable until the next update.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            tgl_meta_reg <= 1'h0;
            tgl_sync_reg <= 1'h0;
            tgl_seen_reg <= 1'h0;
        end else begin
            tgl_meta_reg <= upd_tgl_reg;
            tgl_sync_reg <= tgl_meta_reg;
            tgl_seen_reg <= tgl_sync_reg;
        end
    end

    // Preloaded values handed to the output pins once the toggle edge arrives.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_bsr_drive <= '0;
        end else if (tgl_sync_reg != tgl_seen_reg) begin
            o_bsr_drive <= bsr_upd_reg;
        end
    end

    // Checks on the test clock.
    tap_reset_five_a: assert property (@(posedge i_tck) disable iff (!i_resetn)
        i_tms [*5] |=> state_reg == bst_pkg::ST_RESET)
        else $error("five high test-mode samples did not reach reset");
    ir_reset_ident_a: assert property (@(posedge i_tck) disable iff (!i_resetn)
        state_reg == bst_pkg::ST_RESET |=> ir_reg == bst_pkg::INSTR_IDENT)
        else $error("instruction not identification after reset");
    ir_capture_pat_a: assert property (@(posedge i_tck) disable iff (!i_resetn)
        state_reg == bst_pkg::ST_CAP_IR |=> ir_shift_reg[1:0] == bst_pkg::IR_CAPTURE_PAT)
        else $error("instruction capture pattern wrong");
    ir_update_only_a: assert property (@(posedge i_tck) disable iff (!i_resetn)
        state_reg != bst_pkg::ST_UPD_IR && state_reg != bst_pkg::ST_RESET |=> $stable(ir_reg))
        else $error("instruction changed outside update");
    ir_shift_msb_a: assert property (@(posedge i_tck) disable iff (!i_resetn)
        state_reg == bst_pkg::ST_SHIFT_IR ##1 state_reg == bst_pkg::ST_SHIFT_IR
        |=> ir_shift_reg[1] == $past(i_tdi, 2) && ir_shift_reg[2] == $past(i_tdi))
        else $error("instruction shift order wrong");
    bypass_zero_a: assert property (@(posedge i_tck) disable iff (!i_resetn)
        state_reg == bst_pkg::ST_CAP_DR && ir_reg == bst_pkg::INSTR_BYPASS
        |=> bypass_reg == 1'h0)
        else $error("bypass cell did not capture zero");
    id_capture_a: assert property (@(posedge i_tck) disable iff (!i_resetn)
        state_reg == bst_pkg::ST_CAP_DR && ir_reg == bst_pkg::INSTR_IDENT
        |=> id_reg == ID_WORD && id_reg[0] == 1'h1)
        else $error("identification word not captured");
    tdo_enable_a: assert property (@(posedge i_tck) disable iff (!i_resetn)
        o_tdo_oe == (state_reg == bst_pkg::ST_SHIFT_IR || state_reg == bst_pkg::ST_SHIFT_DR))
        else $error("serial output enable out of step with shift states");
    bus_preset_a: assert property (@(posedge i_tck) disable iff (!i_resetn)
        state_reg == bst_pkg::ST_RESET |=> bsr_upd_reg[BUS_CELL] == 1'h1)
        else $error("bus control cell not preset high");
    float_mode_a: assert property (@(posedge i_tck) disable iff (!i_resetn)
        instr_now == bst_pkg::INSTR_SAMPLE_FLT && state_reg != bst_pkg::ST_RESET
        |=> mode_reg.float_all && !mode_reg.drive_bsr)
        else $error("float sample did not float the outputs");
    extest_bus_a: assert property (@(posedge i_tck) disable iff (!i_resetn)
        instr_now == bst_pkg::INSTR_EXT_TEST && state_reg != bst_pkg::ST_RESET
        |=> mode_reg.bus_enable == bsr_upd_reg[BUS_CELL])
        else $error("bus enable does not follow the control cell");

    // Main scenarios.
    cov_bypass_c:  cover property (@(posedge i_tck) disable iff (!i_resetn)
        state_reg == bst_pkg::ST_SHIFT_DR && ir_reg == bst_pkg::INSTR_BYPASS);
    cov_ident_c:   cover property (@(posedge i_tck) disable iff (!i_resetn)
        state_reg == bst_pkg::ST_SHIFT_DR && ir_reg == bst_pkg::INSTR_IDENT);
    cov_extest_c:  cover property (@(posedge i_tck) disable iff (!i_resetn)
        ir_reg == bst_pkg::INSTR_EXT_TEST && state_reg == bst_pkg::ST_UPD_DR);
    cov_reset_c:   cover property (@(posedge i_tck) disable iff (!i_resetn)
        state_reg == bst_pkg::ST_UPD_IR ##1 i_tms [*5]);

endmodule : bst_tap

// >>> dv/bst_jtag_ctl.sv
// Behavioural board test controller that drives the test port pins.
`timescale 1ns/10ps
module bst_jtag_ctl (
    // Test port pins.
    output logic      o_tck,
    output logic      o_tms,
    output logic      o_tdi,
    input  wire logic i_tdo
);
    // The clock stands low between frames; both pulled-up inputs rest high.
    initial begin
        o_tck = 1'h0;
        o_tms = 1'h1;
        o_tdi = 1'h1;
    end
    // One clock: inputs change while low, output is taken midway through the low phase, 8 ns before the rise.
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        o_tms = tms;
        o_tdi = tdi;
        #8 tdo = i_tdo;
        #8 o_tck = 1'h1;
        #16 o_tck = 1'h0;
    endtask : step
    // Five high samples force test-logic reset, then one low sample parks in idle.
    task automatic tap_reset;
        logic b;
        for (int i = 0; i < 5; i++) step(1'h1, 1'h1, b);
        step(1'h0, 1'h1, b);
    endtask : tap_reset
    // Idle, capture, shift n bits LSB first, update, back to idle.
    task automatic scan(input logic ir, input int n, input logic [84:0] din,
                        output logic [84:0] dout);
        logic b;
        dout = '0;
        step(1'h1, 1'h1, b);
        if (ir) step(1'h1, 1'h1, b);
        step(1'h0, 1'h1, b);
        step(1'h0, 1'h1, b);
        for (int i = 0; i < n; i++) step(i == n - 1, din[i], dout[i]);
        step(1'h1, 1'h1, b);
        step(1'h0, 1'h1, b);
        o_tdi = 1'h1;
    endtask : scan
endmodule : bst_jtag_ctl

// >>> dv/test_boundary_scan_tap.sv
// Self-checking bench of the boundary-scan test access port.
`timescale 1ns/10ps
module test_boundary_scan_tap;
    logic               clk, resetn, tck, tms, tdi, tdo, tdo_oe, tdo_line;
    logic [84:0]        pins, drive, got;
    bst_pkg::bst_mode_t mode;
    int                 n_mismatch, samples_checked;
    // Identification fields are arbitrary values.
    localparam logic [31:0] ID_WORD = {3'h5, 17'h1b2c4, 11'h3c1, 1'h1};
    localparam logic [84:0] PRE     = 85'h0f0f_0f0f_0f0f_0f0f_0f0f;

    bst_tap #(.ID_REVISION(3'h5), .ID_DEVICE(17'h1b2c4), .ID_MAKER(11'h3c1)) i_bst_tap (
        .i_clk(clk), .i_resetn(resetn), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
        .o_tdo(tdo), .o_tdo_oe(tdo_oe), .i_pin_state(pins), .o_mode(mode),
        .o_bsr_drive(drive));
    // A released serial line shows the inverse of the last bit, so a late enable is caught.
    assign tdo_line = tdo_oe ? tdo : ~tdo;
    bst_jtag_ctl i_bst_jtag_ctl (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .i_tdo(tdo_line));

    // Memory clock.
    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end
    // Counts one comparison and reports a miss.
    task automatic check(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'h1) begin
            n_mismatch++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask : check
    task automatic finish_test;
        $display("mismatches %0d, checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test
    // Lets the memory-side controls follow a test clock change.
    task automatic settle;
        repeat (6) @(negedge clk);
    endtask : settle
    // Loads an instruction and checks the captured low bits.
    task automatic load_ir(input logic [2:0] code);
        i_bst_jtag_ctl.scan(1'h1, 3, {82'h0, code}, got);
        check(got[1:0] === bst_pkg::IR_CAPTURE_PAT, "instruction capture");
    endtask : load_ir
    task automatic t_idcode;
        i_bst_jtag_ctl.scan(1'h0, 32, '0, got);
        check(got[31:0] === ID_WORD, "identification word");
    endtask : t_idcode
    // Bypass and every reserved code give a one-bit path that captures low.
    task automatic t_bypass;
        logic [2:0] codes[4] = '{3'h7, 3'h3, 3'h5, 3'h6};
        foreach (codes[k]) begin
            load_ir(codes[k]);
            i_bst_jtag_ctl.scan(1'h0, 4, 85'hb, got);
            check(got[3:0] === 4'h6, "one-bit path");
        end
    endtask : t_bypass
    // Sample snapshot, preload with the bus cell low, then external test and float.
    task automatic t_boundary;
        load_ir(3'h4);
        i_bst_jtag_ctl.scan(1'h0, 85, PRE, got);
        check(got === {1'h1, pins[83:0]}, "pin snapshot");
        settle();
        check(mode === bst_pkg::MODE_NORMAL, "sample disturbed memory");
        load_ir(3'h0);
        settle();
        check(mode === 3'h5, "external test mode");
        check(drive === PRE, "preloaded drive");
        load_ir(3'h2);
        settle();
        check(mode === 3'h1, "float mode");
    endtask : t_boundary
    task automatic t_tap_reset;
        i_bst_jtag_ctl.tap_reset();
        settle();
        check(mode === bst_pkg::MODE_NORMAL, "mode after reset");
        t_idcode();
    endtask : t_tap_reset

    // Watchdog against a hung sequence.
    initial begin
        #100000;
        n_mismatch++;
        finish_test();
    end
    // Main sequence.
    initial begin
        logic b;
        n_mismatch = 0;
        samples_checked = 0;
        resetn = 1'h0;
        pins = 85'h0_dead_beef_cafe_1234_5678;
        i_bst_jtag_ctl.step(1'h1, 1'h1, b);
        i_bst_jtag_ctl.step(1'h1, 1'h1, b);
        @(negedge clk) resetn = 1'h1;
        check(tdo_oe === 1'h0, "serial output not floating");
        check(mode === bst_pkg::MODE_NORMAL, "mode at power-up");
        i_bst_jtag_ctl.step(1'h0, 1'h1, b);
        t_idcode();
        t_bypass();
        t_boundary();
        t_tap_reset();
        finish_test();
    end
endmodule : test_boundary_scan_tap
